// ==== supply_monitor_gain_pkg.sv ====
package supply_monitor_gain_pkg;
  localparam int GAIN_W = 8;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam int CUR_GAIN_LSB = 0;
  localparam int NOLOAD_LSB = 2;
  localparam int ABS_SUM_BIT = 4;
  localparam int VOLT_GAIN_LSB = 5;
  localparam int STAT_W = 16;
  localparam int STAT_LOW_SUPPLY_BIT = 0;
  localparam int SAMPLE_DIV = 12;
  localparam logic [3:0] SAMPLE_DIV_LAST = 4'hb;
  localparam int FILT_LEN = 16;
  localparam logic [4:0] FILT_MAX = 5'h10;
  localparam int SAMPLE_W = 24;
  localparam int DECIM_LOG2 = 8;
  localparam logic [7:0] DECIM_LAST = 8'hff;
  typedef enum logic [1:0] {
    GAIN_X1 = 2'b00,
    GAIN_X2 = 2'b01,
    GAIN_X4 = 2'b10
  } gain_sel_t;
  typedef enum {SUPPLY_OK, SUPPLY_LOW} supply_state_t;
endpackage : supply_monitor_gain_pkg

// ==== supply_monitor_gain_ctrl.sv ====
`timescale 1ns/1ps
module supply_monitor_gain_ctrl
  import supply_monitor_gain_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reset_n_pin,
  input wire logic analog_supply_low,
  input wire logic gain_wr,
  input wire logic [GAIN_W-1:0] gain_wdata,
  output logic [GAIN_W-1:0] analog_gain_config,
  input wire logic status_rd,
  output logic [STAT_W-1:0] status_read_clear_reg,
  input wire logic [STAT_W-1:0] irq_enable,
  input wire logic [STAT_W-1:0] event_set,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic accum_enable,
  output logic [2:0] current_amp_gain_x,
  output logic [2:0] voltage_amp_gain_x,
  output logic [1:0] noload_sel,
  output logic abs_sum_sel,
  output logic mod_sample_en,
  input wire logic [2:0] cur_mod_bits,
  input wire logic [2:0] volt_mod_bits,
  output logic [SAMPLE_W-1:0] cur_sample [3],
  output logic [SAMPLE_W-1:0] volt_sample [3],
  output logic sample_valid
);

  function automatic logic [2:0] gain_factor(input logic [1:0] code);
    unique case (code)
      GAIN_X2: gain_factor = 3'd2;
      GAIN_X4: gain_factor = 3'd4;
      default: gain_factor = 3'd1;
    endcase
  endfunction : gain_factor

  ////////////////////////////////////////////////////////////////////////////
  logic rpin_s1_reg, rpin_s2_reg, sup_s1_reg, sup_s2_reg;
  logic rst;
  always_ff @(posedge mclk) begin
    rpin_s1_reg <= reset_n_pin;
    rpin_s2_reg <= rpin_s1_reg;
    sup_s1_reg <= analog_supply_low;
    sup_s2_reg <= sup_s1_reg;
  end
  assign rst = sys_rst | ~rpin_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // gain register, read back directly
  logic [GAIN_W-1:0] gain_reg, gain_next;
  always_comb begin
    gain_next = gain_reg;
    if (gain_wr) begin
      gain_next = gain_wdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      gain_reg <= GAIN_RESET;
    end else begin
      gain_reg <= gain_next;
    end
  end
  assign analog_gain_config = gain_reg;
  // one field per channel, shared by phases a, b, c
  assign current_amp_gain_x =
    gain_factor(gain_reg[CUR_GAIN_LSB +: 2]);
  assign voltage_amp_gain_x =
    gain_factor(gain_reg[VOLT_GAIN_LSB +: 2]);
  assign noload_sel = gain_reg[NOLOAD_LSB +: 2];
  assign abs_sum_sel = gain_reg[ABS_SUM_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // supply filter: counter must saturate both ways to change state
  supply_state_t sup_state_reg, sup_state_next;
  logic [4:0] filt_reg, filt_next;
  logic low_enter;
  always_comb begin
    filt_next = filt_reg;
    sup_state_next = sup_state_reg;
    low_enter = 1'b0;
    if (sup_s2_reg && filt_reg != FILT_MAX) begin
      filt_next = filt_reg + 5'd1;
    end else if (!sup_s2_reg && filt_reg != 5'd0) begin
      filt_next = filt_reg - 5'd1;
    end
    unique case (sup_state_reg)
      SUPPLY_OK: if (filt_reg == FILT_MAX) begin
        sup_state_next = SUPPLY_LOW;
        low_enter = 1'b1;
      end
      SUPPLY_LOW: if (filt_reg == 5'd0) begin
        sup_state_next = SUPPLY_OK;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_reg <= 5'd0;
      sup_state_reg <= SUPPLY_OK;
    end else begin
      filt_reg <= filt_next;
      sup_state_reg <= sup_state_next;
    end
  end
  assign accum_enable = (sup_state_reg == SUPPLY_OK) && !rst;

  ////////////////////////////////////////////////////////////////////////////
  // status flags; a set in the read cycle survives the clear
  logic [STAT_W-1:0] stat_reg, stat_next, stat_set, irq_mask;
  always_comb begin
    stat_set = event_set;
    stat_set[STAT_LOW_SUPPLY_BIT] = low_enter;
    stat_next = status_rd ? stat_set : (stat_reg | stat_set);
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end
  assign status_read_clear_reg = stat_reg;
  always_comb begin
    irq_mask = irq_enable;
    irq_mask[STAT_LOW_SUPPLY_BIT] = 1'b0;
  end
  assign irq_n_out = 1'b0;
  assign irq_n_oe = ~(|(stat_reg & irq_mask)); // low oe = pulling low

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] div_reg, div_next;
  always_comb begin
    div_next = (div_reg == SAMPLE_DIV_LAST) ? 4'd0 : div_reg + 4'd1;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_reg <= 4'd0;
    end else begin
      div_reg <= div_next;
    end
  end
  assign mod_sample_en = (div_reg == SAMPLE_DIV_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // boxcar decimator: count of ones over 256 samples, scaled to 24 bits;
  // crude but keeps area tiny, no noise shaping filter
  logic [DECIM_LOG2-1:0] dcnt_reg, dcnt_next;
  logic [5:0] mbits;
  logic [DECIM_LOG2:0] acc_reg [6];
  logic [DECIM_LOG2:0] acc_next [6];
  logic [SAMPLE_W-1:0] smp_reg [6];
  logic [SAMPLE_W-1:0] smp_next [6];
  logic valid_reg, valid_next;
  logic dump;
  assign mbits = {volt_mod_bits, cur_mod_bits};
  assign dump = mod_sample_en && dcnt_reg == DECIM_LAST;
  always_comb begin
    dcnt_next = mod_sample_en ? dcnt_reg + 8'd1 : dcnt_reg;
    valid_next = dump;
  end
  for (genvar i = 0; i < 6; i++) begin : g_dec
    always_comb begin
      acc_next[i] = acc_reg[i];
      smp_next[i] = smp_reg[i];
      if (mod_sample_en) begin
        acc_next[i] = dump ? '0 : acc_reg[i] + {8'd0, mbits[i]};
      end
      if (dump) begin
        smp_next[i] = {acc_reg[i] + {8'd0, mbits[i]}, 15'd0};
      end
    end
    always_ff @(posedge mclk) begin
      if (rst) begin
        acc_reg[i] <= '0;
        smp_reg[i] <= '0;
      end else begin
        acc_reg[i] <= acc_next[i];
        smp_reg[i] <= smp_next[i];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      dcnt_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      dcnt_reg <= dcnt_next;
      valid_reg <= valid_next;
    end
  end
  for (genvar p = 0; p < 3; p++) begin : g_out
    assign cur_sample[p] = smp_reg[p];
    assign volt_sample[p] = smp_reg[p+3];
  end
  assign sample_valid = valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_low_blocks_accum: assert property (@(posedge mclk) disable iff (rst)
    sup_state_reg == SUPPLY_LOW |-> !accum_enable)
    else $error("accumulation active while supply low");
  a_filter_needs_run: assert property (@(posedge mclk) disable iff (rst)
    $rose(sup_state_reg == SUPPLY_LOW) |-> $past(filt_reg) == FILT_MAX)
    else $error("low state entered without full filter");
  a_low_sets_flag: assert property (@(posedge mclk) disable iff (rst)
    low_enter |=> stat_reg[STAT_LOW_SUPPLY_BIT])
    else $error("low-supply flag not set");
  a_low_never_irq: assert property (@(posedge mclk) disable iff (rst)
    !(|(stat_reg & irq_enable & ~(16'd1 << STAT_LOW_SUPPLY_BIT)))
    |-> irq_n_oe)
    else $error("low-supply flag drove irq");
  a_gain_two: assert property (@(posedge mclk)
    gain_reg[CUR_GAIN_LSB +: 2] == GAIN_X2 |-> current_amp_gain_x == 3'd2)
    else $error("current gain code 01 not x2");
  a_volt_gain: assert property (@(posedge mclk)
    gain_reg[VOLT_GAIN_LSB +: 2] == GAIN_X4 |-> voltage_amp_gain_x == 3'd4)
    else $error("voltage gain code 10 not x4");
  a_div_twelve: assert property (@(posedge mclk) disable iff (rst)
    mod_sample_en |=> !mod_sample_en [*8] ##1 !mod_sample_en [*3]
    ##1 mod_sample_en)
    else $error("sample enable not every 12 clocks");
  a_read_clears: assert property (@(posedge mclk) disable iff (rst)
    status_rd && event_set == '0 && !low_enter |=> stat_reg == '0)
    else $error("status not cleared by read");
  a_reset_unity: assert property (@(posedge mclk)
    $past(rst) |-> current_amp_gain_x == 3'd1)
    else $error("gain not unity after reset");
  c_supply_low: cover property (@(posedge mclk) low_enter);
  c_sample_out: cover property (@(posedge mclk) sample_valid);
  c_irq_active: cover property (@(posedge mclk) !irq_n_oe);
  c_read_clear: cover property (@(posedge mclk) status_rd && |stat_reg);

endmodule : supply_monitor_gain_ctrl

// ==== host_mcu_model.sv ====
`timescale 1ns/1ps
module host_mcu_model
  import supply_monitor_gain_pkg::*;
(
  input wire logic mclk,
  output logic gain_wr,
  output logic [GAIN_W-1:0] gain_wdata,
  output logic status_rd,
  input wire logic [STAT_W-1:0] status_read_clear_reg
);
  // polls status; never waits on the irq pin
  initial begin
    gain_wr = 1'b0;
    gain_wdata = 8'h00;
    status_rd = 1'b0;
  end
  task automatic write_gain(input logic [GAIN_W-1:0] v);
    @(posedge mclk);
    #1;
    gain_wr = 1'b1;
    gain_wdata = v;
    @(posedge mclk);
    #1;
    gain_wr = 1'b0;
    gain_wdata = ~v; // no stale data once released
  endtask : write_gain
  task automatic read_status(output logic [STAT_W-1:0] v);
    @(posedge mclk);
    #1;
    status_rd = 1'b1;
    @(posedge mclk);
    v = status_read_clear_reg;
    #1;
    status_rd = 1'b0;
  endtask : read_status
endmodule : host_mcu_model

// ==== tb_supply_monitor_gain_ctrl.sv ====
`timescale 1ns/1ps
module tb_supply_monitor_gain_ctrl;
  import supply_monitor_gain_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic rst_pin_n = 1'b1;
  logic low = 1'b0;
  logic gain_wr, status_rd, irq_n_out, irq_n_oe, acc, abs_sum, s_en, s_vld;
  logic [GAIN_W-1:0] gain_wdata, gain_q;
  logic [STAT_W-1:0] stat_q, st, irq_en = 16'hffff, ev = 16'h0000;
  logic [2:0] cur_g, volt_g;
  logic [1:0] noload;
  logic [SAMPLE_W-1:0] cur_s [3];
  logic [SAMPLE_W-1:0] volt_s [3];
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  always #2 mclk = ~mclk;
  supply_monitor_gain_ctrl uut (.mclk(mclk), .sys_rst(sys_rst),
    .reset_n_pin(rst_pin_n), .analog_supply_low(low), .gain_wr(gain_wr),
    .gain_wdata(gain_wdata), .analog_gain_config(gain_q),
    .status_rd(status_rd), .status_read_clear_reg(stat_q),
    .irq_enable(irq_en), .event_set(ev), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .accum_enable(acc), .current_amp_gain_x(cur_g),
    .voltage_amp_gain_x(volt_g), .noload_sel(noload),
    .abs_sum_sel(abs_sum), .mod_sample_en(s_en), .cur_mod_bits(3'b101),
    .volt_mod_bits(3'b010), .cur_sample(cur_s), .volt_sample(volt_s),
    .sample_valid(s_vld));
  host_mcu_model host (.mclk(mclk), .gain_wr(gain_wr),
    .gain_wdata(gain_wdata), .status_rd(status_rd),
    .status_read_clear_reg(stat_q));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [23:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // waits for acc to reach level v, counting cycles
  task automatic wait_acc(input logic v);
    n = 0;
    while (acc !== v && n < 60) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask : wait_acc
  //////////////////////////////////////////////////////////////////////////
  task automatic test_gain;
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {1'b1, c[1:0], c[0], c[1:0], c[1:0]};
      host.write_gain(v);
      check("gain_readback", gain_q, v);
      check("cur_gain", cur_g, c == 1 ? 2 : c == 2 ? 4 : 1);
      check("volt_gain", volt_g, c == 1 ? 2 : c == 2 ? 4 : 1);
      check("noload", noload, c[1:0]);
      check("abs_sum", abs_sum, c[0]);
    end
  endtask : test_gain
  task automatic test_supply;
    low = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    low = 1'b0;
    repeat (24) @(posedge mclk);
    #1;
    check("glitch_acc", acc, 1'b1);
    check("glitch_flag", stat_q[0], 1'b0);
    low = 1'b1;
    wait_acc(1'b0);
    check("filter_delay", n >= 17 && n <= 22, 1'b1);
    check("low_acc", acc, 1'b0);
    check("low_flag", stat_q[0], 1'b1);
    check("low_irq", irq_n_oe, 1'b1);
    host.read_status(st);
    check("rd_flag", st[0], 1'b1);
    check("rd_clear", stat_q, 16'h0000);
    low = 1'b0;
    wait_acc(1'b1);
    check("back_acc", acc, 1'b1);
  endtask : test_supply
  task automatic test_event;
    @(posedge mclk);
    #1;
    ev = 16'h0002;
    @(posedge mclk);
    #1;
    ev = 16'h0000;
    check("ev_irq", irq_n_oe, 1'b0);
    check("irq_level", irq_n_out, 1'b0);
    host.read_status(st);
    check("ev_flag", st, 16'h0002);
    check("ev_release", irq_n_oe, 1'b1);
  endtask : test_event
  task automatic test_sampling;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (s_en !== 1'b1 && n < 30);
    end
    check("div_period", n, 12);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (s_vld !== 1'b1 && n < 4000);
    end
    check("vld_seen", s_vld, 1'b1);
    check("cur0", cur_s[0], 24'h80_0000);
    check("cur2", cur_s[2], 24'h80_0000);
    check("volt0", volt_s[0], 24'h00_0000);
    check("cur1", cur_s[1], 24'h00_0000);
    check("volt1", volt_s[1], 24'h80_0000);
    check("volt2", volt_s[2], 24'h00_0000);
  endtask : test_sampling
  task automatic test_pin_reset;
    host.write_gain(8'h41);
    rst_pin_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    check("pin_gain", gain_q, 8'h00);
    check("pin_acc", acc, 1'b0);
    rst_pin_n = 1'b1;
  endtask : test_pin_reset
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    check("rst_gain", gain_q, 8'h00);
    check("rst_cur", cur_g, 3'h1);
    check("rst_irq", irq_n_oe, 1'b1);
    test_gain();
    test_supply();
    test_event();
    test_sampling();
    test_pin_reset();
    finish_test();
  end
  // the sampling test needs about 6200 cycles
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb_supply_monitor_gain_ctrl
